// >>> design/ubg_top.sv
// Bit-rate tick generator for a four-mode serial port, with its APB registers.
// Assumes the Timer 1 overflow pulse and the transmit request come from logic
// on sys_clk, so neither is synchronised.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ubg_top (
  input  wire logic                  sys_clk,        // Core clock, 50 MHz
  input  wire logic                  rst,            // Synchronous, active high
  input  wire ubg_pkg::ubg_apb_req_t apbReq,         // APB request group
  output logic [ubg_pkg::DATA_W-1:0] prdata,         // APB read data
  output logic                       pready,         // APB ready
  output logic                       pslverr,        // APB error, unmapped address
  input  wire logic                  timer1Overflow, // One pulse per Timer 1 overflow
  input  wire logic                  txRequest,      // Pulse on transmit buffer write
  output logic                       txBitTick,      // Transmit bit enable pulse
  output logic                       rxBitTick,      // Receive bit enable pulse
  output logic                       txStartGo       // Frame start pulse for shifter
);
  import ubg_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  ubg_cfg_t          cfg_q;         // Software configuration
  logic              pready_q;      // Access-phase answer
  logic              pslverr_q;     // Error flag for the answer
  logic [DATA_W-1:0] prdata_q;      // Captured read data
  logic [DATA_W-1:0] rdData;        // Read mux
  logic              wrEn;          // Write takes effect this edge
  logic [3:0]        m0Cnt_q;       // Divide-by-12 counter
  logic [5:0]        m2Cnt_q;       // Divide-by-64/32 counter
  logic [4:0]        t1Cnt_q;       // Timer 1 overflow counter
  logic [15:0]       t2Cnt_q;       // Timer 2 count
  logic              t2Phase_q;     // Timer 2 half-rate prescaler
  logic [3:0]        t2Div_q;       // Timer 2 overflow counter
  logic              txPending_q;   // Transmit request waiting for a tick
  logic              txTick_q;      // Registered transmit tick
  logic              rxTick_q;      // Registered receive tick
  logic              txGo_q;        // Registered frame start
  logic              m0Tick;        // Shift-mode rate event
  logic              m2Tick;        // Fixed nine-bit rate event
  logic              t1BitTick;     // Timer 1 derived bit event
  logic              t2Run;         // Timer 2 in rate-generator mode
  logic              t2Step;        // Timer 2 increments this cycle
  logic              t2Load;        // Reload word written this edge
  logic              t2Ovf;         // Timer 2 overflow this cycle
  logic              t2BitTick;     // Timer 2 derived bit event
  logic              txSrc;         // Selected transmit event
  logic              rxSrc;         // Selected receive event
  logic [4:0]        t1Last;        // Timer 1 terminal count

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  // Address is one of the five mapped words
  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    isMapped = (addr == OFS_SERIAL_CTRL) || (addr == OFS_POWER_CTRL) ||
               (addr == OFS_TIMER2_CTRL) || (addr == OFS_TIMER2_RELOAD) ||
               (addr == OFS_STATUS);
  endfunction

  // Pick the rate event for one direction from mode and Timer 2 select
  function automatic logic pickSource(input logic [1:0] mode, input logic selT2,
                                      input logic ev0, input logic ev2,
                                      input logic evT1, input logic evT2);
    case (mode)
      MODE_SHIFT: pickSource = ev0;
      MODE_FIX9:  pickSource = ev2;
      default:    pickSource = selT2 ? evT2 : evT1;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  // Write lands only at the edge where ready is sampled high
  assign wrEn = apbReq.psel && apbReq.penable && pready_q && apbReq.pwrite &&
                isMapped(apbReq.paddr);

  // Read mux; unused bits read zero
  always_comb begin
    rdData = '0;
    case (apbReq.paddr)
      OFS_SERIAL_CTRL: begin
        rdData[SER_MODE_HI_POS] = cfg_q.serMode[1];
        rdData[SER_MODE_LO_POS] = cfg_q.serMode[0];
      end
      OFS_POWER_CTRL: begin
        rdData[RATE_DOUBLE_POS] = cfg_q.rateDouble;
      end
      OFS_TIMER2_CTRL: begin
        rdData[TX_T2_POS] = cfg_q.txT2;
        rdData[RX_T2_POS] = cfg_q.rxT2;
      end
      OFS_TIMER2_RELOAD: begin
        rdData[RELOAD_HI_POS +: 8] = cfg_q.t2Reload[15:8];
        rdData[RELOAD_LO_POS +: 8] = cfg_q.t2Reload[7:0];
      end
      OFS_STATUS: begin
        rdData[STAT_T2CNT_POS +: 16] = t2Cnt_q;
        rdData[STAT_PENDING_POS]     = txPending_q;
        rdData[STAT_T2RUN_POS]       = t2Run;
      end
      default: begin
        rdData = '0;
      end
    endcase
  end

  // One wait state: ready rises after the first access cycle, for one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (apbReq.psel && apbReq.penable && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= !isMapped(apbReq.paddr);
      prdata_q  <= apbReq.pwrite ? '0 : rdData;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Configuration registers; status word ignores writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
    end else if (wrEn) begin
      case (apbReq.paddr)
        OFS_SERIAL_CTRL: begin
          cfg_q.serMode <= {apbReq.pwdata[SER_MODE_HI_POS],
                            apbReq.pwdata[SER_MODE_LO_POS]}; // RL12
        end
        OFS_POWER_CTRL: begin
          cfg_q.rateDouble <= apbReq.pwdata[RATE_DOUBLE_POS];
        end
        OFS_TIMER2_CTRL: begin
          cfg_q.txT2 <= apbReq.pwdata[TX_T2_POS]; // RL10
          cfg_q.rxT2 <= apbReq.pwdata[RX_T2_POS]; // RL10
        end
        OFS_TIMER2_RELOAD: begin
          cfg_q.t2Reload <= {apbReq.pwdata[RELOAD_HI_POS +: 8],
                             apbReq.pwdata[RELOAD_LO_POS +: 8]};
        end
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Fixed-rate dividers
  // ---------------------------------------------------------------------------
  // Free running so a mode switch finds the divider already in phase
  assign m0Tick = (m0Cnt_q == MODE0_LAST); // RL1
  assign m2Tick = cfg_q.rateDouble ? (m2Cnt_q[4:0] == M2_LAST_FAST)
                                   : (m2Cnt_q == M2_LAST_SLOW); // RL2

  // Divide by 12
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      m0Cnt_q <= '0;
    end else begin
      m0Cnt_q <= m0Tick ? 4'h0 : m0Cnt_q + 4'h1; // RL1
    end
  end

  // Divide by 64; its low five bits give divide by 32
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      m2Cnt_q <= '0;
    end else begin
      m2Cnt_q <= m2Cnt_q + 6'h01; // RL2
    end
  end

  // ---------------------------------------------------------------------------
  // Timer 1 overflow divider
  // ---------------------------------------------------------------------------
  // Only the overflow pulse is seen, so the timer's mode and source do not matter
  assign t1Last    = cfg_q.rateDouble ? T1_LAST_FAST : T1_LAST_SLOW;
  assign t1BitTick = timer1Overflow && (t1Cnt_q >= t1Last); // RL4 RL5 RL6

  // Greater-or-equal keeps the count sane if doubling is set mid-count
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t1Cnt_q <= '0;
    end else if (timer1Overflow) begin
      t1Cnt_q <= t1BitTick ? 5'h00 : t1Cnt_q + 5'h01; // RL4
    end
  end

  // ---------------------------------------------------------------------------
  // Timer 2 in rate-generator mode
  // ---------------------------------------------------------------------------
  assign t2Run     = cfg_q.txT2 || cfg_q.rxT2; // RL10
  assign t2Step    = t2Run && t2Phase_q; // RL9
  assign t2Load    = wrEn && (apbReq.paddr == OFS_TIMER2_RELOAD); // RL11
  assign t2Ovf     = t2Step && (t2Cnt_q == T2_TOP);
  assign t2BitTick = t2Ovf && (t2Div_q == T2_DIV_LAST); // RL8

  // Half-rate prescaler, held clear while Timer 2 is idle
  // A preset restarts it so the preset count also lasts two cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t2Phase_q <= 1'b0;
    end else begin
      t2Phase_q <= t2Run && !t2Phase_q && !t2Load; // RL9
    end
  end

  // Count up, reload on overflow; holds while not selected
  // A reload write also presets the count unless an overflow reloads it that cycle, so a new rate needs no full 16-bit wrap
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t2Cnt_q <= '0;
    end else if (t2Ovf) begin
      t2Cnt_q <= cfg_q.t2Reload; // RL11
    end else if (t2Load) begin
      t2Cnt_q <= {apbReq.pwdata[RELOAD_HI_POS +: 8], apbReq.pwdata[RELOAD_LO_POS +: 8]};
    end else if (t2Step) begin
      t2Cnt_q <= t2Cnt_q + 16'h0001;
    end
  end

  // Sixteen overflows per bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t2Div_q <= '0;
    end else if (t2Ovf) begin
      t2Div_q <= t2Div_q + 4'h1; // RL8
    end
  end

  // ---------------------------------------------------------------------------
  // Source selection and tick outputs
  // ---------------------------------------------------------------------------
  assign txSrc = pickSource(cfg_q.serMode, cfg_q.txT2, m0Tick, m2Tick,
                            t1BitTick, t2BitTick); // RL3 RL12 RL14
  assign rxSrc = pickSource(cfg_q.serMode, cfg_q.rxT2, m0Tick, m2Tick,
                            t1BitTick, t2BitTick); // RL3 RL12 RL14

  // Registered so each tick is one clean cycle wide
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txTick_q <= 1'b0;
      rxTick_q <= 1'b0;
    end else begin
      txTick_q <= txSrc; // RL15
      rxTick_q <= rxSrc; // RL15
    end
  end

  // Request waits for the next tick; a new request in the serving cycle survives
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txPending_q <= 1'b0;
      txGo_q      <= 1'b0;
    end else begin
      txPending_q <= txRequest || (txPending_q && !txSrc); // RL13
      txGo_q      <= txPending_q && txSrc; // RL13
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign txBitTick = txTick_q;
  assign rxBitTick = rxTick_q;
  assign txStartGo = txGo_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // A period check waits one full new period after a write, so the first short tick is skipped
  logic [7:0] gapCnt_q;        // Cycles since last transmit tick
  logic [7:0] cfgAge_q;        // Cycles since last config write

  // Helper counters, saturating
  always_ff @(posedge sys_clk) begin
    if (rst || txTick_q) begin
      gapCnt_q <= '0;
    end else if (gapCnt_q != 8'hFF) begin
      gapCnt_q <= gapCnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || wrEn) begin
      cfgAge_q <= '0;
    end else if (cfgAge_q != 8'hFF) begin
      cfgAge_q <= cfgAge_q + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_mode0_period: assert property (txTick_q && cfgAge_q > MODE0_DIV && // RL1
    cfg_q.serMode == MODE_SHIFT |-> gapCnt_q == MODE0_DIV - 1)
    else $error("shift mode tick period is not 12");
  a_mode2_slow: assert property (txTick_q && cfgAge_q > MODE2_SLOW && // RL2
    cfg_q.serMode == MODE_FIX9 && !cfg_q.rateDouble |-> gapCnt_q == MODE2_SLOW - 1)
    else $error("fixed mode slow period is not 64");
  a_mode2_fast: assert property (txTick_q && cfgAge_q > MODE2_FAST && // RL2
    cfg_q.serMode == MODE_FIX9 && cfg_q.rateDouble |-> gapCnt_q == MODE2_FAST - 1)
    else $error("fixed mode fast period is not 32");
  a_t1_source: assert property (cfg_q.serMode[0] && !cfg_q.txT2 && // RL14
    $stable(cfg_q) && txTick_q |-> $past(timer1Overflow))
    else $error("timer 1 tick without overflow");
  a_t1_count: assert property (timer1Overflow && t1Cnt_q < t1Last |-> !t1BitTick ##1 // RL4
    t1Cnt_q == $past(t1Cnt_q) + 5'h01)
    else $error("timer 1 overflow counter misbehaves");
  a_t2_source: assert property (cfg_q.serMode[0] && cfg_q.rxT2 && // RL10
    $stable(cfg_q) && rxTick_q |-> $past(t2Ovf) && $past(t2Div_q) == T2_DIV_LAST)
    else $error("timer 2 receive tick not on sixteenth overflow");
  a_t2_reload: assert property (t2Step && t2Cnt_q == T2_TOP |=> // RL11
    t2Cnt_q == $past(cfg_q.t2Reload))
    else $error("timer 2 did not reload");
  a_t2_half_rate: assert property ($changed(t2Cnt_q) |=> $stable(t2Cnt_q)) // RL9
    else $error("timer 2 stepped on consecutive cycles");
  a_tick_single: assert property (txTick_q |=> !txTick_q) // RL15
    else $error("transmit tick wider than one cycle");
  a_go_on_tick: assert property (txGo_q |-> txTick_q && $past(txPending_q)) // RL13
    else $error("frame start not on a tick");
  a_pend_served: assert property (txPending_q && txSrc |=> txGo_q) // RL13
    else $error("pending transmit missed its tick");

  c_mode0_tick: cover property (cfg_q.serMode == MODE_SHIFT && txTick_q);
  c_mode2_fast: cover property (cfg_q.serMode == MODE_FIX9 && cfg_q.rateDouble && txTick_q);
  c_t2_rx_tick: cover property (cfg_q.rxT2 && cfg_q.serMode == MODE_VAR9 && rxTick_q);
  c_tx_go:      cover property (txGo_q);

endmodule

`default_nettype wire

// >>> design/ubg_pkg.sv
// Constants, field layouts and carrier types of the serial bit-rate generator.
// Assumes one 50 MHz core clock, an APB master and an external Timer 1 block.
//
// Function
// RL1 - Shift mode ticks at core clock over 12
// RL2 - Fixed nine-bit mode divides by 64 or 32
// RL3 - Variable modes take rate from timer overflows
// RL4 - Timer 1: bit per 32 or 16 overflows
// RL5 - Any Timer 1 overflow source is accepted
// RL6 - Autoreload Timer 1 rate follows the formula
// RL7 - Software keeps Timer 1 interrupt disabled
// RL8 - Timer 2: sixteen overflows per bit
// RL9 - Timer 2 steps every two core clocks
// RL10 - Timer 2 select bits route each direction
// RL11 - Timer 2 reloads from sixteen-bit reload pair
// RL12 - Two mode bits choose the serial mode
// RL13 - Transmission starts at next bit tick only
// RL14 - Clear Timer 2 select falls back to Timer 1
// RL15 - Ticks are single-cycle pulses per direction

package ubg_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry and register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_SERIAL_CTRL   = 12'h000; // serial_control_reg
  localparam logic [ADDR_W-1:0] OFS_POWER_CTRL    = 12'h004; // power_control_reg
  localparam logic [ADDR_W-1:0] OFS_TIMER2_CTRL   = 12'h008; // timer2_control_reg
  localparam logic [ADDR_W-1:0] OFS_TIMER2_RELOAD = 12'h00C; // high and low reload bytes
  localparam logic [ADDR_W-1:0] OFS_STATUS        = 12'h010; // Read-only state

  // Field positions
  localparam int unsigned SER_MODE_HI_POS   = 7;  // serial_mode_bit_hi
  localparam int unsigned SER_MODE_LO_POS   = 6;  // serial_mode_bit_lo
  localparam int unsigned RATE_DOUBLE_POS   = 7;  // rate_double_bit
  localparam int unsigned TX_T2_POS         = 4;  // tx_rate_from_timer2
  localparam int unsigned RX_T2_POS         = 5;  // rx_rate_from_timer2
  localparam int unsigned RELOAD_LO_POS     = 0;  // timer2_reload_low at [7:0]
  localparam int unsigned RELOAD_HI_POS     = 8;  // timer2_reload_high at [15:8]
  localparam int unsigned STAT_T2CNT_POS    = 0;  // Timer 2 count at [15:0]
  localparam int unsigned STAT_PENDING_POS  = 16; // Transmit request waiting
  localparam int unsigned STAT_T2RUN_POS    = 17; // Timer 2 in rate mode

  // ---------------------------------------------------------------------------
  // Serial mode codes, {hi, lo}
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_VAR8  = 2'h1;
  localparam logic [1:0] MODE_FIX9  = 2'h2;
  localparam logic [1:0] MODE_VAR9  = 2'h3;

  // ---------------------------------------------------------------------------
  // Divider figures and derived terminal counts
  // ---------------------------------------------------------------------------
  localparam int unsigned MODE0_DIV   = 12;
  localparam int unsigned MODE2_SLOW  = 64;
  localparam int unsigned MODE2_FAST  = 32;
  localparam int unsigned T1_OVF_SLOW = 32;
  localparam int unsigned T1_OVF_FAST = 16;
  localparam int unsigned T2_OVF_PER  = 16;

  localparam logic [3:0]  MODE0_LAST   = 4'(MODE0_DIV - 1);
  localparam logic [5:0]  M2_LAST_SLOW = 6'(MODE2_SLOW - 1);
  localparam logic [4:0]  M2_LAST_FAST = 5'(MODE2_FAST - 1);
  localparam logic [4:0]  T1_LAST_SLOW = 5'(T1_OVF_SLOW - 1);
  localparam logic [4:0]  T1_LAST_FAST = 5'(T1_OVF_FAST - 1);
  localparam logic [3:0]  T2_DIV_LAST  = 4'(T2_OVF_PER - 1);
  localparam logic [15:0] T2_TOP       = 16'hFFFF;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ubg_apb_req_t;

  typedef struct packed {
    logic [1:0]  serMode;    // {serial_mode_bit_hi, serial_mode_bit_lo}
    logic        rateDouble; // rate_double_bit
    logic        txT2;       // tx_rate_from_timer2
    logic        rxT2;       // rx_rate_from_timer2
    logic [15:0] t2Reload;   // {timer2_reload_high, timer2_reload_low}
  } ubg_cfg_t;

  localparam ubg_cfg_t CFG_RESET = '0;

endpackage

// >>> sim/ubg_shifter_model.sv
// Behavioural model of the serial shifters that consume the bit ticks.
// Assumes every input is a registered pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module ubg_shifter_model (
  input  wire logic        sys_clk,   // Core clock
  input  wire logic        rst,       // Synchronous, active high
  input  wire logic        txBitTick, // Transmit bit enable
  input  wire logic        rxBitTick, // Receive bit enable
  input  wire logic        txStartGo, // Frame start
  output logic      [31:0] txGap,     // Cycles between last two tx ticks
  output logic      [31:0] rxGap,     // Cycles between last two rx ticks
  output logic      [31:0] txStarts,  // Frames begun
  output logic      [31:0] badStarts  // Starts seen off a tick
);
  logic [31:0] txAge_q; // Cycles since last tx tick
  logic [31:0] rxAge_q; // Cycles since last rx tick

  // ---------------------------------------------------------------
  // Tick spacing, as each shifter sees it
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txAge_q <= '0;
      rxAge_q <= '0;
      txGap   <= '0;
      rxGap   <= '0;
    end else begin
      // Separate counts: the two directions may run at unlike rates
      txAge_q <= txBitTick ? 32'h1 : txAge_q + 32'h1;
      rxAge_q <= rxBitTick ? 32'h1 : rxAge_q + 32'h1;
      if (txBitTick) txGap <= txAge_q;
      if (rxBitTick) rxGap <= rxAge_q;
    end
  end

  // ---------------------------------------------------------------
  // Frame starts; a shifter can only begin on a bit tick
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txStarts  <= '0;
      badStarts <= '0;
    end else if (txStartGo) begin
      txStarts <= txStarts + 32'h1;
      if (!txBitTick) badStarts <= badStarts + 32'h1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/uart_baud_rate_generator_bench.sv
// Self-checking bench for the bit-rate tick generator.
// Assumes the shifter model beside it and a bench-made Timer 1.
`timescale 1ns/1ps
`default_nettype none

module uart_baud_rate_generator_bench;
  import ubg_pkg::*;
  logic              sys_clk, rst, timer1Overflow, txRequest;
  logic              pready, pslverr, txBitTick, rxBitTick, txStartGo;
  ubg_apb_req_t      apbReq;                 // APB request group
  logic [DATA_W-1:0] prdata, rdVal, s1;      // Read data and copies
  logic              rdErr;                  // Last error response
  logic [31:0]       txGap, rxGap, txStarts, badStarts;
  logic [7:0]        t1Reload;               // timer1_reload_byte
  logic [11:0]       t1Cnt, t1Last;          // Timer 1 prescaled count
  int                failures, num_checks, n;
  localparam logic [31:0] T1P = 32'h0C * (32'h100 - 32'hFD); // Overflow period

  ubg_top u_dut (.sys_clk(sys_clk), .rst(rst), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer1Overflow(timer1Overflow),
    .txRequest(txRequest), .txBitTick(txBitTick), .rxBitTick(rxBitTick),
    .txStartGo(txStartGo));
  ubg_shifter_model u_shift (.sys_clk(sys_clk), .rst(rst), .txBitTick(txBitTick),
    .rxBitTick(rxBitTick), .txStartGo(txStartGo), .txGap(txGap), .rxGap(rxGap),
    .txStarts(txStarts), .badStarts(badStarts));

  always #10 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // Timer 1 in 8-bit autoreload timer mode, interrupt left off
  // ---------------------------------------------------------------
  assign t1Last = 12'h00C * (12'h100 - {4'h0, t1Reload}) - 12'h001;
  always @(posedge sys_clk) begin
    timer1Overflow <= !rst && (t1Cnt == t1Last);
    t1Cnt <= (rst || t1Cnt == t1Last) ? 12'h000 : t1Cnt + 12'h001;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int w;
    w = 0;
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && w < 20) begin
      @(posedge sys_clk);
      w++;
    end
    if (w >= 20) failures++;
    rdVal = prdata;
    rdErr = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    // Idle cycle so the next setup never lands in the same time step
    @(posedge sys_clk);
  endtask

  // Wait for three ticks on each side; the first after a change may be short
  task automatic settle();
    int t, r, c;
    t = 0;
    r = 0;
    c = 0;
    while ((t < 3 || r < 3) && c < 5000) begin
      @(posedge sys_clk);
      c++;
      if (txBitTick === 1'b1) t++;
      if (rxBitTick === 1'b1) r++;
    end
    if (c >= 5000) failures++;
    @(posedge sys_clk);
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog; the slowest scenarios wait three Timer 1 bit periods of 1152 cycles
  initial begin
    repeat (25000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    apbReq = '0;
    txRequest = 1'b0;
    t1Reload = 8'hFD;
    failures = 0;
    num_checks = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check({29'h0, txBitTick, rxBitTick, txStartGo}, 32'h0);
    xfer(1'b0, OFS_SERIAL_CTRL, 32'h0);
    check(rdVal, 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    check({31'h0, rdErr}, 32'h1);
    // Timer 2 on transmit: it must enter rate mode and step every two cycles
    xfer(1'b1, OFS_TIMER2_RELOAD, 32'hFFF0);
    xfer(1'b1, OFS_TIMER2_CTRL, 32'h10);
    xfer(1'b0, OFS_STATUS, 32'h0);
    s1 = rdVal;
    xfer(1'b0, OFS_STATUS, 32'h0);
    check({31'h0, rdVal[STAT_T2RUN_POS]}, 32'h1);
    check({16'h0, rdVal[15:0] - s1[15:0]}, 32'h2);
    // Shift mode ignores doubling and timer selects
    settle();
    check(txGap, 32'h0C);
    xfer(1'b1, OFS_POWER_CTRL, 32'h80);
    settle();
    check(rxGap, 32'h0C);
    // Transmit request is served only at a later tick
    txRequest <= 1'b1;
    @(posedge sys_clk);
    txRequest <= 1'b0;
    n = 0;
    while (txStartGo !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check({31'h0, n >= 2 && n <= 14}, 32'h1);
    check({31'h0, txBitTick}, 32'h1);
    // Fixed nine-bit mode, doubled then plain
    xfer(1'b1, OFS_SERIAL_CTRL, 32'h80);
    settle();
    check(txGap, 32'h20);
    xfer(1'b1, OFS_POWER_CTRL, 32'h0);
    settle();
    check(rxGap, 32'h40);
    // Variable nine-bit mode: tx from Timer 2, rx falls back to Timer 1
    xfer(1'b1, OFS_SERIAL_CTRL, 32'hC0);
    settle();
    check(txGap, 32'h20 * (32'h10000 - 32'hFFF0));
    check(rxGap, 32'h20 * T1P);
    // Swap directions
    xfer(1'b1, OFS_TIMER2_CTRL, 32'h20);
    settle();
    check(rxGap, 32'h20 * (32'h10000 - 32'hFFF0));
    check(txGap, 32'h20 * T1P);
    // Variable eight-bit mode on Timer 1 alone, doubled
    xfer(1'b1, OFS_SERIAL_CTRL, 32'h40);
    xfer(1'b1, OFS_TIMER2_CTRL, 32'h0);
    xfer(1'b1, OFS_POWER_CTRL, 32'h80);
    settle();
    check(txGap, 32'h10 * T1P);
    check(rxGap, 32'h10 * T1P);
    check(txStarts, 32'h1);
    check(badStarts, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
